// ==== design/p4fs_top.v ====
/*
 port 4: eight gpio pins with drive options and a
 function select handing pins 0..2 to two serial ports.
 assumes an avalon-mm master on i_clk, pad cells that
 resolve out/oe/pull signals, serial ports on i_clk.
*/
// Notes on behaviour
// - pin 0 field: gpio, serial1_data_in, serial0_data_in, bad
// - pin 1 field: gpio, serial1_clock, serial0_clock, bad
// - pin 2 field: gpio, serial1_data_out, serial0_data_out, bad
// - selects reset zero, high upper bits zero
// - low select takes byte or word access
// - bad code: hiz, pch outputs float
// - bad code: nch, cmos outputs forced low
// - one direction bit per pin
// - output drive: hiz, pch, nch, cmos
// - input: hiz, pull-down or pull-up
// - reset leaves pins hiz outputs
// - output pin follows data register bit
// - input mode read returns pin level
// - low three pins carry serial functions
// - direction 0 output, 1 input
// - drive field codes per mode
`include "p4fs_defs.vh"

module p4fs_top #(
    parameter PINS = 8
) (
    input  wire            i_clk,
    input  wire            i_rst_n,
    input  wire [17:0]     i_avs_address,
    input  wire            i_avs_read,
    input  wire            i_avs_write,
    input  wire [31:0]     i_avs_writedata,
    input  wire [3:0]      i_avs_byteenable,
    output reg  [31:0]     o_avs_readdata,
    output wire            o_avs_waitrequest,
    input  wire [PINS-1:0] i_pin_in,
    output reg  [PINS-1:0] o_pin_out,
    output reg  [PINS-1:0] o_pin_oe,
    output reg  [PINS-1:0] o_pull_up,
    output reg  [PINS-1:0] o_pull_down,
    input  wire            i_serial0_clock_out,
    input  wire            i_serial0_data_out,
    input  wire            i_serial1_clock_out,
    input  wire            i_serial1_data_out,
    output reg             o_serial0_data_in,
    output reg             o_serial0_clock_in,
    output reg             o_serial1_data_in,
    output reg             o_serial1_clock_in
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_IDLE = 1'b0;
localparam ST_ACK  = 1'b1;

// ----------------------------------------
// functions
// ----------------------------------------
// byte-lane merge of an 8-bit register
function [7:0] p4fs_merge;
    input [7:0] old;
    input [7:0] wdat;
    input       be;
    begin
        p4fs_merge = be ? wdat : old;
    end
endfunction

// pad drive {oe, out, pull_up, pull_down}
function [3:0] p4fs_drive;
    input       dir;
    input [1:0] cfg;
    input       dat;
    input       bad;
    begin
        p4fs_drive = 4'h0;
        if (dir == `P4FS_DIR_OUT) begin
            case (cfg)
                `P4FS_DRV_HIZ: begin
                    p4fs_drive = 4'h0;
                end
                `P4FS_DRV_PCH: begin
                    // high only; bad code floats
                    if (dat && !bad) begin
                        p4fs_drive = 4'hc;
                    end
                end
                `P4FS_DRV_NCH: begin
                    if (!dat || bad) begin
                        p4fs_drive = 4'h8;
                    end
                end
                `P4FS_DRV_CMOS: begin
                    if (bad) begin
                        p4fs_drive = 4'h8;
                    end else begin
                        p4fs_drive = {1'b1, dat, 2'h0};
                    end
                end
                default: begin
                    p4fs_drive = 4'h0;
                end
            endcase
        end else begin
            case (cfg)
                `P4FS_IN_PD: begin
                    p4fs_drive = 4'h1;
                end
                `P4FS_IN_PU: begin
                    p4fs_drive = 4'h2;
                end
                default: begin
                    p4fs_drive = 4'h0;
                end
            endcase
        end
    end
endfunction

// output source of a serial-capable pin
function p4fs_source;
    input [1:0] func;
    input       gpio;
    input       ser1;
    input       ser0;
    begin
        case (func)
            `P4FS_FUNC_SER1: begin
                p4fs_source = ser1;
            end
            `P4FS_FUNC_SER0: begin
                p4fs_source = ser0;
            end
            default: begin
                p4fs_source = gpio;
            end
        endcase
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg                      state;
reg                      next_state;
reg  [PINS-1:0]          data_reg;
reg  [PINS-1:0]          dir_reg;
reg  [PINS-1:0]          drv_lo;
reg  [PINS-1:0]          drv_hi;
reg  [7:0]               fsel_lo;
reg  [`P4FS_FHI_BITS-1:0] fsel_hi;
reg  [31:0]              next_rdata;
reg  [PINS-1:0]          next_out;
reg  [PINS-1:0]          next_oe;
reg  [PINS-1:0]          next_pu;
reg  [PINS-1:0]          next_pd;
reg  [PINS-1:0]          src;
reg  [3:0]               drv;
wire [PINS-1:0]          pin_sync;
wire [PINS-1:0]          pin_read;
wire [1:0]               func0;
wire [1:0]               func1;
wire [1:0]               func2;
wire                     req;
wire                     commit;
wire [7:0]               wb0;
wire [7:0]               wb1;
integer                  n;

// ----------------------------------------
// pin input synchroniser
// ----------------------------------------
p4fs_sync #(
    .WIDTH (PINS)
) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_pin_in),
    .o_sync  (pin_sync)
);

// ----------------------------------------
// bus handshake
// ----------------------------------------
// one wait state gives time to register readdata
assign req               = i_avs_read | i_avs_write;
assign o_avs_waitrequest = req & (state == ST_IDLE);
assign commit            = i_avs_write & (state == ST_ACK);
assign wb0               = i_avs_writedata[7:0];
assign wb1               = i_avs_writedata[15:8];

always @* begin
    case (state)
        ST_IDLE: begin
            next_state = req ? ST_ACK : ST_IDLE;
        end
        ST_ACK: begin
            next_state = ST_IDLE;
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        state <= ST_IDLE;
    end else begin
        state <= next_state;
    end
end

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        data_reg <= `P4FS_RST_BYTE;
        dir_reg  <= `P4FS_RST_BYTE;
        drv_lo   <= `P4FS_RST_BYTE;
        drv_hi   <= `P4FS_RST_BYTE;
        fsel_lo  <= `P4FS_RST_BYTE;
        fsel_hi  <= `P4FS_RST_FHI;
    end else if (commit) begin
        case (i_avs_address)
            `P4FS_ADDR_DATA: begin
                data_reg <= p4fs_merge(data_reg, wb0, i_avs_byteenable[0]);
            end
            `P4FS_ADDR_DIR: begin
                dir_reg <= p4fs_merge(dir_reg, wb0, i_avs_byteenable[0]);
            end
            `P4FS_ADDR_DRV_LO: begin
                // word view covers the high drive byte
                drv_lo <= p4fs_merge(drv_lo, wb0, i_avs_byteenable[0]);
                drv_hi <= p4fs_merge(drv_hi, wb1, i_avs_byteenable[1]);
            end
            `P4FS_ADDR_DRV_HI: begin
                drv_hi <= p4fs_merge(drv_hi, wb0, i_avs_byteenable[0]);
            end
            `P4FS_ADDR_FSEL_LO: begin
                fsel_lo <= p4fs_merge(fsel_lo, wb0, i_avs_byteenable[0]);
                if (i_avs_byteenable[1]) begin
                    fsel_hi <= wb1[`P4FS_FHI_BITS-1:0];
                end
            end
            `P4FS_ADDR_FSEL_HI: begin
                if (i_avs_byteenable[0]) begin
                    fsel_hi <= wb0[`P4FS_FHI_BITS-1:0];
                end
            end
            default: begin
                data_reg <= data_reg;
            end
        endcase
    end
end

// ----------------------------------------
// register reads
// ----------------------------------------
// input-mode bits show the pin, output bits the latch;
// a read-modify-write thus copies pin levels into
// the latch of input bits
genvar g;
generate
    for (g = 0; g < PINS; g = g + 1) begin : g_read
        assign pin_read[g] = (dir_reg[g] == `P4FS_DIR_OUT) ?
                             data_reg[g] : pin_sync[g];
    end
endgenerate

always @* begin
    case (i_avs_address)
        `P4FS_ADDR_DATA: begin
            next_rdata = {24'h000000, pin_read};
        end
        `P4FS_ADDR_DIR: begin
            next_rdata = {24'h000000, dir_reg};
        end
        `P4FS_ADDR_DRV_LO: begin
            next_rdata = {`P4FS_WORD_PAD, drv_hi, drv_lo};
        end
        `P4FS_ADDR_DRV_HI: begin
            next_rdata = {24'h000000, drv_hi};
        end
        `P4FS_ADDR_FSEL_LO: begin
            next_rdata = {`P4FS_WORD_PAD, `P4FS_HI_PAD, fsel_hi,
                          fsel_lo};
        end
        `P4FS_ADDR_FSEL_HI: begin
            next_rdata = {24'h000000, `P4FS_HI_PAD, fsel_hi};
        end
        default: begin
            next_rdata = 32'h00000000;
        end
    endcase
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && state == ST_IDLE) begin
        o_avs_readdata <= next_rdata;
    end
end

// ----------------------------------------
// function fields
// ----------------------------------------
assign func0 = {fsel_hi[0], fsel_lo[0]};
assign func1 = {fsel_hi[1], fsel_lo[1]};
assign func2 = {fsel_hi[2], fsel_lo[2]};

// ----------------------------------------
// pad drive
// ----------------------------------------
// the direction bit still governs serial pins, so the
// serial clock pin is output or input as software sets
always @* begin
    src    = data_reg;
    src[1] = p4fs_source(func1, data_reg[1],
                         i_serial1_clock_out,
                         i_serial0_clock_out);
    src[2] = p4fs_source(func2, data_reg[2],
                         i_serial1_data_out,
                         i_serial0_data_out);
    next_out = {PINS{1'b0}};
    next_oe  = {PINS{1'b0}};
    next_pu  = {PINS{1'b0}};
    next_pd  = {PINS{1'b0}};
    drv      = 4'h0;
    for (n = 0; n < PINS; n = n + 1) begin
        drv = p4fs_drive(dir_reg[n], {drv_hi[n], drv_lo[n]},
                         src[n], (n == 0 && func0 == `P4FS_FUNC_BAD) ||
                         (n == 1 && func1 == `P4FS_FUNC_BAD) ||
                         (n == 2 && func2 == `P4FS_FUNC_BAD));
        next_oe[n]  = drv[3];
        next_out[n] = drv[2];
        next_pu[n]  = drv[1];
        next_pd[n]  = drv[0];
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_pin_out   <= {PINS{1'b0}};
        o_pin_oe    <= {PINS{1'b0}};
        o_pull_up   <= {PINS{1'b0}};
        o_pull_down <= {PINS{1'b0}};
    end else begin
        o_pin_out   <= next_out;
        o_pin_oe    <= next_oe;
        o_pull_up   <= next_pu;
        o_pull_down <= next_pd;
    end
end

// ----------------------------------------
// serial port inputs
// ----------------------------------------
// unselected ports see a steady low
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_serial0_data_in  <= 1'b0;
        o_serial0_clock_in <= 1'b0;
        o_serial1_data_in  <= 1'b0;
        o_serial1_clock_in <= 1'b0;
    end else begin
        o_serial0_data_in  <= (func0 == `P4FS_FUNC_SER0) & pin_sync[0];
        o_serial1_data_in  <= (func0 == `P4FS_FUNC_SER1) & pin_sync[0];
        o_serial0_clock_in <= (func1 == `P4FS_FUNC_SER0) & pin_sync[1];
        o_serial1_clock_in <= (func1 == `P4FS_FUNC_SER1) & pin_sync[1];
    end
end

endmodule // p4fs_top

// ==== design/p4fs_defs.vh ====
/*
 constants for the port 4 pin function select block.
 assumes a 32-bit avalon-mm slave with byte addresses.
*/
`ifndef P4FS_DEFS_VH
`define P4FS_DEFS_VH

// ----------------------------------------
// register indexes and byte addresses
// ----------------------------------------
`define P4FS_IDX_DATA    16'hf220
`define P4FS_IDX_DIR     16'hf221
`define P4FS_IDX_DRV_LO  16'hf222
`define P4FS_IDX_DRV_HI  16'hf223
`define P4FS_IDX_FSEL_LO 16'hf224
`define P4FS_IDX_FSEL_HI 16'hf225
`define P4FS_ADDR_DATA    {`P4FS_IDX_DATA, 2'h0}
`define P4FS_ADDR_DIR     {`P4FS_IDX_DIR, 2'h0}
`define P4FS_ADDR_DRV_LO  {`P4FS_IDX_DRV_LO, 2'h0}
`define P4FS_ADDR_DRV_HI  {`P4FS_IDX_DRV_HI, 2'h0}
`define P4FS_ADDR_FSEL_LO {`P4FS_IDX_FSEL_LO, 2'h0}
`define P4FS_ADDR_FSEL_HI {`P4FS_IDX_FSEL_HI, 2'h0}

// ----------------------------------------
// reset values
// ----------------------------------------
`define P4FS_RST_BYTE 8'h00
`define P4FS_RST_FHI  3'h0

// ----------------------------------------
// field layout
// ----------------------------------------
`define P4FS_FHI_BITS 3
`define P4FS_HI_PAD   5'h00
`define P4FS_WORD_PAD 16'h0000

// ----------------------------------------
// encodings
// ----------------------------------------
`define P4FS_DIR_OUT   1'b0
`define P4FS_FUNC_GPIO 2'h0
`define P4FS_FUNC_SER1 2'h1
`define P4FS_FUNC_SER0 2'h2
`define P4FS_FUNC_BAD  2'h3
`define P4FS_DRV_HIZ   2'h0
`define P4FS_DRV_PCH   2'h1
`define P4FS_DRV_NCH   2'h2
`define P4FS_DRV_CMOS  2'h3
`define P4FS_IN_PD     2'h1
`define P4FS_IN_PU     2'h2

`endif

// ==== design/p4fs_sync.v ====
/*
 two flip-flop synchroniser for the port pins.
 assumes asynchronous pin levels and one system clock.
*/
module p4fs_sync #(
    parameter WIDTH = 8
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);

// ----------------------------------------
// stages
// ----------------------------------------
// first stage feeds only the second
reg [WIDTH-1:0] meta;

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        meta   <= {WIDTH{1'b0}};
        o_sync <= {WIDTH{1'b0}};
    end else begin
        meta   <= i_async;
        o_sync <= meta;
    end
end

endmodule // p4fs_sync

// ==== bench/p4fs_pad_model.sv ====
/*
 pad and far-side model for port 4 pins.
 assumes pad signals from p4fs_top and an external driver set by the bench.
*/
module p4fs_pad_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pu,
    input  wire logic [7:0] i_pd,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output wire logic [7:0] o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // pin resolution
    // ----------------------------------------
    // undriven pins with no pull toggle, so a stale level never passes for a real one
    logic [7:0] wob = 8'h55;
    always @(posedge i_clk) begin
        wob <= ~wob;
    end
    assign o_level = (i_oe & i_out) | (~i_oe & ((i_ext_en & i_ext_val)
                   | (~i_ext_en & (i_pu | (~i_pd & wob)))));
endmodule // p4fs_pad_model

// ==== bench/p4fs_monitor.sv ====
/*
 port checker for p4fs_top.
 assumes one clock and an asynchronous active-low reset.
*/
module p4fs_monitor #(
    parameter PINS = 8
) (
    input wire logic            i_clk,
    input wire logic            i_rst_n,
    input wire logic [17:0]     i_avs_address,
    input wire logic            i_avs_read,
    input wire logic            i_avs_write,
    input wire logic [31:0]     o_avs_readdata,
    input wire logic            o_avs_waitrequest,
    input wire logic [PINS-1:0] i_pin_in,
    input wire logic [PINS-1:0] o_pin_oe,
    input wire logic [PINS-1:0] o_pull_up,
    input wire logic [PINS-1:0] o_pull_down,
    input wire logic            o_serial0_data_in,
    input wire logic            o_serial0_clock_in,
    input wire logic            o_serial1_data_in,
    input wire logic            o_serial1_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic [15:0] idx;
    assign idx = i_avs_address[17:2];
    a_rst_hiz: assert property ($rose(i_rst_n) |-> o_pin_oe == 0 && (o_pull_up | o_pull_down) == 0)
        else $error("pins not idle after reset");
    a_write_wait: assert property ($rose(i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("write wait wrong");
    a_read_wait: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("read wait wrong");
    a_pull_excl: assert property ((o_pull_up & o_pull_down) == 0)
        else $error("both pulls on");
    a_pull_input: assert property (((o_pull_up | o_pull_down) & o_pin_oe) == 0)
        else $error("pull on driven pin");
    a_serial0_data_in_path: assert property (o_serial0_data_in |-> $past(i_pin_in[0], 3))
        else $error("serial0 data in wrong");
    a_serial1_data_in_path: assert property (o_serial1_data_in |-> $past(i_pin_in[0], 3))
        else $error("serial1 data in wrong");
    a_serial0_clock_path: assert property (o_serial0_clock_in |-> $past(i_pin_in[1], 3))
        else $error("serial0 clock in wrong");
    a_serial1_clock_path: assert property (o_serial1_clock_in |-> $past(i_pin_in[1], 3))
        else $error("serial1 clock in wrong");
    a_sin_onehot: assert property (!(o_serial0_data_in && o_serial1_data_in))
        else $error("both data ins set");
    a_fhi_pad: assert property (i_avs_read && !o_avs_waitrequest && idx == 16'hf225
        |-> o_avs_readdata[7:3] == 0)
        else $error("select high upper bits set");
    a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
        && (idx > 16'hf225 || idx < 16'hf220) |-> o_avs_readdata == 0)
        else $error("unmapped read not zero");
    c_write: cover property (i_avs_write && !o_avs_waitrequest);
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
    c_serial: cover property (o_serial0_data_in);
endmodule // p4fs_monitor

bind p4fs_top p4fs_monitor #(.PINS(PINS)) p4fs_monitor_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_pin_in(i_pin_in), .o_pin_oe(o_pin_oe),
    .o_pull_up(o_pull_up), .o_pull_down(o_pull_down), .o_serial0_data_in(o_serial0_data_in),
    .o_serial0_clock_in(o_serial0_clock_in), .o_serial1_data_in(o_serial1_data_in),
    .o_serial1_clock_in(o_serial1_clock_in));

// ==== bench/p4fs_tb_top.sv ====
/*
 self-checking bench for p4fs_top.
 assumes the pad model and the bound checker.
*/
module p4fs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [17:0] addr = 18'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'h0;
    logic [31:0] rdata, q;
    logic        wreq, s0c = 1'b0, s0d = 1'b0, s1c = 1'b0, s1d = 1'b0;
    logic        si0d, si0c, si1d, si1c;
    logic [7:0]  pin, pout, poe, ppu, ppd, ext_en = 8'h0, ext_val = 8'h0;
    logic [7:0]  b [0:13];
    int          fail_count = 0, total_checks = 0;
    // dir dlo dhi dat flo fhi en ev | oe oe&out pu pd mask rd
    logic [111:0] rows [0:4] = '{112'h00aacc0f_00000000_ca0a0000ff0f,
        112'h00aaccf0_00000000_aca00000fff0, 112'hffaacc00_00000000_00004422_6644,
        112'hff000000_0000ffa5_00000000ffa5, 112'h000d0eff_07070000_0e080000ffff};
    // idx wdata be expect
    logic [51:0] acc [0:5] = '{52'hf225_00ff_1_0007, 52'hf224_ff05_3_0705,
        52'hf224_0002_1_0702, 52'hf226_ffff_3_0000,
        52'hf223_00a5_1_00a5, 52'hf222_3c5a_1_a55a};

    always #5 clk = ~clk;

    p4fs_top p4fs_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pin_in(pin), .o_pin_out(pout),
        .o_pin_oe(poe), .o_pull_up(ppu), .o_pull_down(ppd), .i_serial0_clock_out(s0c),
        .i_serial0_data_out(s0d), .i_serial1_clock_out(s1c), .i_serial1_data_out(s1d),
        .o_serial0_data_in(si0d), .o_serial0_clock_in(si0c), .o_serial1_data_in(si1d),
        .o_serial1_clock_in(si1c));
    p4fs_pad_model p4fs_pad_model_inst (.i_clk(clk), .i_out(pout), .i_oe(poe), .i_pu(ppu),
        .i_pd(ppd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d,
                       input logic [3:0] e, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= {idx, 2'h0};
        wd <= {16'h0, d};
        be <= e;
        // judged at rising edges only; request held until then
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected pins at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected read at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 14; k++) b[k] = rows[i][8*(13-k) +: 8];
            bus(1'b1, 16'hf221, {8'h0, b[0]}, 4'h1, q);
            bus(1'b1, 16'hf222, {b[2], b[1]}, 4'h3, q);
            bus(1'b1, 16'hf220, {8'h0, b[3]}, 4'h1, q);
            bus(1'b1, 16'hf224, {b[5], b[4]}, 4'h3, q);
            ext_en <= b[6];
            ext_val <= b[7];
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk_pin(poe, b[8]);
            chk_pin(pout & poe, b[9]);
            chk_pin(ppu, b[10]);
            chk_pin(ppd, b[11]);
            bus(1'b0, 16'hf220, 16'h0, 4'h1, q);
            chk_rd({8'h0, q[7:0] & b[12]}, {8'h0, b[13]});
        end
        // serial ports take pins 0..2; data register set against serial0's outputs, equal to serial1's
        bus(1'b1, 16'hf221, 16'h0001, 4'h1, q);
        bus(1'b1, 16'hf222, 16'hfffe, 4'h3, q);
        bus(1'b1, 16'hf220, 16'h0004, 4'h1, q);
        ext_en <= 8'h01;
        ext_val <= 8'h01;
        s0c <= 1'b1;
        s1d <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 16'hf224, k ? 16'h0007 : 16'h0700, 4'h3, q);
            repeat (5) @(posedge clk);
            @(negedge clk);
            chk_pin(poe, 8'hfe);
            chk_pin({pout[2:1], 2'h0, si0d, si1d, si0c, si1c}, k ? 8'h84 : 8'h4a);
        end
        // second reset in mid-run; pin 0 pull-up is on before it
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_pin(poe, 8'h00);
        chk_pin(ppu | ppd, 8'h00);
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, 16'hf220 + 16'(k), 16'h0, 4'h3, q);
            chk_rd(q[15:0], 16'h0000);
        end
        for (int k = 0; k < 6; k++) begin
            bus(1'b1, acc[k][51:36], acc[k][35:20], acc[k][19:16], q);
            bus(1'b0, acc[k][51:36], 16'h0, 4'h3, q);
            chk_rd(q[15:0], acc[k][15:0]);
        end
        tally_and_finish();
    end
endmodule // p4fs_tb_top
